// *** verilog/mcr_pkg.sv ***
`default_nettype none
package mcr_pkg;
    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] MCR_OFS_STATUS1  = 8'h41;
    localparam logic [7:0] MCR_OFS_STATUS2  = 8'h42;
    localparam logic [7:0] MCR_OFS_MASK1    = 8'h43;
    localparam logic [7:0] MCR_OFS_MASK2    = 8'h44;
    localparam logic [7:0] MCR_OFS_INTR_CLR = 8'h46;
    localparam logic [7:0] MCR_OFS_VID_FAN  = 8'h47;
    localparam logic [7:0] MCR_OFS_BUS_ADDR = 8'h48;
    localparam logic [7:0] MCR_OFS_VID_HIGH = 8'h49;
    localparam logic [7:0] MCR_OFS_TEMP_CFG = 8'h4b;

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int          MCR_INTR_CLR_BIT    = 7;
    localparam int          MCR_TEMP_STATUS_BIT = 4;
    localparam int          MCR_CHS_STATUS_BIT  = 4;
    localparam logic [6:0]  MCR_INTR_LOW_RST    = 7'h00;
    localparam logic [1:0]  MCR_PRESCALE_RST    = 2'h0;
    localparam logic [5:0]  MCR_BUS_ADDR_PREFIX = 6'h0b;
    localparam logic [6:0]  MCR_VID_HIGH_RST    = 7'h40;
    localparam logic [1:0]  MCR_TEMP_MODE_RST   = 2'h1;
    localparam logic [4:0]  MCR_TEMP_RESV_RST   = 5'h00;
    localparam logic [7:0]  MCR_MASK_RST        = 8'h00;
    localparam logic [1:0]  MCR_MODE_ONE_TIME   = 2'h1;
    localparam logic [1:0]  MCR_MODE_COMPARATOR = 2'h2;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int          MCR_SYS_CLK_KHZ       = 10000;
    localparam int          MCR_CLEAR_PULSE_MS    = 20;
    localparam int          MCR_CLEAR_PULSE_CYCLES = MCR_CLEAR_PULSE_MS * MCR_SYS_CLK_KHZ;
    localparam logic [1:0]  MCR_ADDR_LOAD_DELAY   = 2'h3;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [2:0] {
        MCR_ST_IDLE   = 3'h0,
        MCR_ST_ADDR   = 3'h1,
        MCR_ST_PTR    = 3'h3,
        MCR_ST_WDATA  = 3'h2,
        MCR_ST_RDATA  = 3'h6,
        MCR_ST_IGNORE = 3'h7
    } mcr_link_state_type;

    typedef struct packed {
        logic [8:0] reading;
        logic [7:0] hot_limit;
        logic [7:0] hyst_limit;
    } mcr_temp_sample_type;
endpackage
`default_nettype wire

// *** verilog/mcr_monitor_control.sv ***
`default_nettype none
// Notes on behaviour
// (RL1) writing 1 to intrusion clear bit 7 drives the chassis pin low 20 ms
// (RL2) the intrusion clear bit drops back to 0 when the pulse ends
// (RL3) bits 0-3 of the voltage id register mirror the four voltage code pins
// (RL4) bits 4-5 set the first tach prescale: 1, 2, 4 or 8
// (RL5) bits 6-7 set the second tach prescale: 1, 2, 4 or 8
// (RL6) bus address is read-write and powers up as 001011 plus two select pins
// (RL7) fifth id register: bit 0 mirrors fifth pin, bits 1-7 rw, reset 1000000
// (RL8) equal mode bits: default mode, flag above hot limit, cleared by status read
// (RL9) default mode re-raises the flag each conversion until below hysteresis
// (RL10) mode 01: one-time, single flag on exceeding hot limit, held until read
// (RL11) one-time mode: next flag only when temperature first falls below hysteresis
// (RL12) one-time mode: then nothing until the hot limit is exceeded again
// (RL13) mode 10: comparator, alert asserted while above hot limit
// (RL14) comparator alert drops on status read or temperature not above hot limit
// (RL15) temperature config bit 7 reads the ninth, half-degree temperature bit
// (RL16) temperature config bits 2-6 are read-write, reset 00000
// (RL17) status read clears its flags, except chassis which clears by the pulse
// (RL18) a mask bit of 1 keeps its status flag off the interrupt output
// (RL19) pulse timed by a cycle counter never shorter than the minimum
// (RL20) all registers hold defaults before any bus access is taken
module mcr_monitor_control
    import mcr_pkg::*;
#(
    parameter int CLEAR_PULSE_CYCLES = MCR_CLEAR_PULSE_CYCLES
) (
    input  wire logic                sys_clk_in,
    input  wire logic                srst_in,
    input  wire logic                link_clk_in,
    input  wire logic                scl_in,
    input  wire logic                sda_in,
    output logic                     sda_out,
    output logic                     sda_oe_out,
    input  wire logic                addr_select_high_pin_in,
    input  wire logic                addr_select_low_pin_in,
    input  wire logic [3:0]          cpu_voltage_code_inputs_in,
    input  wire logic                voltage_code_fifth_input_in,
    input  wire logic                chassis_intrusion_pin_in,
    output logic                     chassis_intrusion_pin_out,
    output logic                     chassis_intrusion_pin_oe_out,
    input  wire mcr_temp_sample_type temp_sample_in,
    input  wire logic                conv_done_in,
    output logic [1:0]               first_tach_prescale_out,
    output logic [1:0]               second_tach_prescale_out,
    output logic                     system_management_alert_n_out,
    output logic                     hw_int_n_out
);
    localparam int CW = $clog2(CLEAR_PULSE_CYCLES + 1);

    generate
        if (CLEAR_PULSE_CYCLES < 1) begin : g_bad_pulse
            $error("clear pulse count must be at least one cycle");
        end
    endgenerate

    function automatic logic temp_above(input mcr_temp_sample_type s);
        return $signed(s.reading[8:1]) > $signed(s.hot_limit);
    endfunction

    function automatic logic temp_below(input mcr_temp_sample_type s);
        return $signed(s.reading[8:1]) < $signed(s.hyst_limit);
    endfunction

    // ****************************************************************
    // pin synchronisers and link-side capture
    // ****************************************************************
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic       scl_prev;
    logic       sda_prev;
    logic [4:0] vid_sync1;
    logic [4:0] vid_sync2;
    logic [1:0] asel_sync1;
    logic [1:0] asel_sync2;
    logic [1:0] chs_sync;
    logic       link_bit;

    // sda sampled on the link clock; sys side reads it only after the
    // synchronised scl rise, when it has long been stable
    always_ff @(posedge link_clk_in) begin
        link_bit <= sda_in;
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_prev <= scl_sync[1];
            sda_prev <= sda_sync[1];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        vid_sync1  <= {voltage_code_fifth_input_in, cpu_voltage_code_inputs_in};
        vid_sync2  <= vid_sync1;
        asel_sync1 <= {addr_select_high_pin_in, addr_select_low_pin_in};
        asel_sync2 <= asel_sync1;
        chs_sync   <= {chs_sync[0], chassis_intrusion_pin_in};
    end

    wire scl_rise   = scl_sync[1] & ~scl_prev;
    wire scl_fall   = ~scl_sync[1] & scl_prev;
    wire start_cond = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
    wire stop_cond  = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];

    // ****************************************************************
    // power-up load; bus held off until defaults and pins are in
    // ****************************************************************
    logic [1:0] load_cnt;
    logic       bus_ready;

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            load_cnt  <= 2'h0;
            bus_ready <= 1'b0;
        end else if (!bus_ready) begin
            load_cnt  <= load_cnt + 2'h1;
            bus_ready <= (load_cnt == MCR_ADDR_LOAD_DELAY - 2'h1); // RL20
        end
    end

    // ****************************************************************
    // serial slave
    // ****************************************************************
    mcr_link_state_type state;
    logic [3:0]         bit_cnt;
    logic [7:0]         rx;
    logic [7:0]         tx;
    logic [7:0]         ptr;
    logic               master_ack;
    logic [7:0]         bus_address;
    logic [7:0]         rd_byte;

    wire byte_end  = scl_fall & (bit_cnt == 4'h8);
    wire ack_end   = scl_fall & (bit_cnt == 4'h9);
    wire addr_hit  = (rx[7:1] == bus_address[6:0]);
    wire wr_en     = byte_end & (state == MCR_ST_WDATA);
    wire rd_en     = ack_end & (state == MCR_ST_RDATA) & master_ack;
    wire counting  = (state != MCR_ST_IDLE) & (state != MCR_ST_IGNORE);

    always_ff @(posedge sys_clk_in) begin
        if (srst_in || !bus_ready) begin
            state      <= MCR_ST_IDLE;
            bit_cnt    <= 4'h0;
            rx         <= 8'h00;
            tx         <= 8'h00;
            ptr        <= 8'h00;
            master_ack <= 1'b0;
            sda_oe_out <= 1'b0;
        end else if (start_cond) begin
            state      <= MCR_ST_ADDR;
            bit_cnt    <= 4'h0;
            sda_oe_out <= 1'b0;
        end else if (stop_cond) begin
            state      <= MCR_ST_IDLE;
            sda_oe_out <= 1'b0;
        end else begin
            if (scl_rise && counting) begin
                bit_cnt <= bit_cnt + 4'h1;
                if (bit_cnt < 4'h8) begin
                    rx <= {rx[6:0], link_bit};
                end
                if (bit_cnt == 4'h8) begin
                    master_ack <= ~link_bit;
                end
            end
            if (byte_end) begin
                case (state)
                    MCR_ST_ADDR: begin
                        sda_oe_out <= addr_hit;
                        if (!addr_hit) begin
                            state <= MCR_ST_IGNORE;
                        end else if (rx[0]) begin
                            state <= MCR_ST_RDATA;
                        end else begin
                            state <= MCR_ST_PTR;
                        end
                    end
                    MCR_ST_PTR: begin
                        ptr        <= rx;
                        sda_oe_out <= 1'b1;
                        state      <= MCR_ST_WDATA;
                    end
                    MCR_ST_WDATA: begin
                        ptr        <= ptr + 8'h01;
                        sda_oe_out <= 1'b1;
                    end
                    default: begin
                        sda_oe_out <= 1'b0;
                    end
                endcase
            end else if (ack_end) begin
                bit_cnt <= 4'h0;
                if (rd_en) begin
                    tx         <= {rd_byte[6:0], 1'b0};
                    sda_oe_out <= ~rd_byte[7];
                    ptr        <= ptr + 8'h01;
                end else begin
                    sda_oe_out <= 1'b0;
                    if (state == MCR_ST_RDATA) begin
                        state <= MCR_ST_IGNORE;
                    end
                end
            end else if (scl_fall && state == MCR_ST_RDATA && bit_cnt != 4'h0) begin
                sda_oe_out <= ~tx[7];
                tx         <= {tx[6:0], 1'b0};
            end
        end
    end

    // ****************************************************************
    // register bank
    // ****************************************************************
    logic [6:0]    intr_low;
    logic [CW-1:0] pulse_cnt;
    logic [6:0]    vid_high_rw;
    logic [1:0]    temp_mode;
    logic [4:0]    temp_resv;
    logic [7:0]    mask1;
    logic [7:0]    mask2;

    wire wr_clr  = wr_en & (ptr == MCR_OFS_INTR_CLR);
    wire pulse_go = wr_clr & rx[MCR_INTR_CLR_BIT] & ~chassis_intrusion_pin_oe_out;
    wire pulse_last = chassis_intrusion_pin_oe_out &
                      (pulse_cnt == CW'(CLEAR_PULSE_CYCLES - 1));

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            chassis_intrusion_pin_oe_out <= 1'b0;
            pulse_cnt                    <= '0;
        end else if (pulse_go) begin
            chassis_intrusion_pin_oe_out <= 1'b1; // RL1
            pulse_cnt                    <= '0;
        end else if (chassis_intrusion_pin_oe_out) begin
            pulse_cnt <= pulse_cnt + CW'(1); // RL19
            if (pulse_last) begin
                chassis_intrusion_pin_oe_out <= 1'b0; // RL2
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            intr_low                 <= MCR_INTR_LOW_RST;
            first_tach_prescale_out  <= MCR_PRESCALE_RST;
            second_tach_prescale_out <= MCR_PRESCALE_RST;
            vid_high_rw              <= MCR_VID_HIGH_RST; // RL7
            temp_mode                <= MCR_TEMP_MODE_RST;
            temp_resv                <= MCR_TEMP_RESV_RST; // RL16
            mask1                    <= MCR_MASK_RST;
            mask2                    <= MCR_MASK_RST;
        end else if (wr_en) begin
            case (ptr)
                MCR_OFS_INTR_CLR: intr_low <= rx[6:0];
                MCR_OFS_VID_FAN: begin
                    first_tach_prescale_out  <= rx[5:4]; // RL4
                    second_tach_prescale_out <= rx[7:6]; // RL5
                end
                MCR_OFS_VID_HIGH: vid_high_rw <= rx[7:1];
                MCR_OFS_TEMP_CFG: begin
                    temp_mode <= rx[1:0];
                    temp_resv <= rx[6:2];
                end
                MCR_OFS_MASK1: mask1 <= rx;
                MCR_OFS_MASK2: mask2 <= rx;
                default: ;
            endcase
        end
    end

    // address pins caught once the synchronisers have filled
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            bus_address <= 8'h00;
        end else if (!bus_ready && load_cnt == MCR_ADDR_LOAD_DELAY - 2'h1) begin
            bus_address <= {MCR_BUS_ADDR_PREFIX, asel_sync2}; // RL6
        end else if (wr_en && ptr == MCR_OFS_BUS_ADDR) begin
            bus_address <= rx;
        end
    end

    // ****************************************************************
    // temperature and chassis status
    // ****************************************************************
    logic temp_flag;
    logic chs_flag;
    logic hot_latched;
    logic hot_armed;

    wire above      = temp_above(temp_sample_in);
    wire below      = temp_below(temp_sample_in);
    wire mode_dflt  = (temp_mode[0] == temp_mode[1]);
    wire mode_once  = (temp_mode == MCR_MODE_ONE_TIME);
    wire mode_cmp   = (temp_mode == MCR_MODE_COMPARATOR);
    wire rd_status1 = rd_en & (ptr == MCR_OFS_STATUS1);
    wire set_dflt   = conv_done_in & (above | (hot_latched & ~below)); // RL9
    wire set_once   = conv_done_in & (hot_armed ? above : below); // RL11
    wire temp_set   = (mode_dflt & set_dflt) | (mode_once & set_once) |
                      (mode_cmp & conv_done_in & above); // RL13
    wire temp_clr   = rd_status1 | (mode_cmp & conv_done_in & ~above); // RL14
    wire int_cause  = (temp_flag & ~mask1[MCR_TEMP_STATUS_BIT]) |
                      (chs_flag & ~mask2[MCR_CHS_STATUS_BIT]); // RL18

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            temp_flag   <= 1'b0;
            chs_flag    <= 1'b0;
            hot_latched <= 1'b0;
            hot_armed   <= 1'b1;
        end else begin
            // a new event wins over a clearing read in the same cycle
            temp_flag <= temp_set | (temp_flag & ~temp_clr); // RL8
            chs_flag  <= chs_sync[1] | (chs_flag & ~chassis_intrusion_pin_oe_out); // RL17
            if (conv_done_in && above) begin
                hot_latched <= 1'b1;
            end else if (conv_done_in && below) begin
                hot_latched <= 1'b0;
            end
            if (mode_once && set_once) begin
                hot_armed <= ~hot_armed; // RL10 RL12
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            hw_int_n_out                  <= 1'b1;
            system_management_alert_n_out <= 1'b1;
            sda_out                       <= 1'b0;
            chassis_intrusion_pin_out     <= 1'b0;
        end else begin
            hw_int_n_out                  <= ~int_cause;
            system_management_alert_n_out <= ~(mode_cmp & temp_flag &
                                               ~mask1[MCR_TEMP_STATUS_BIT]);
        end
    end

    // ****************************************************************
    // read decode
    // ****************************************************************
    wire [7:0] clr_read  = {chassis_intrusion_pin_oe_out, intr_low}; // RL2
    wire [7:0] vfan_read = {second_tach_prescale_out, first_tach_prescale_out,
                            vid_sync2[3:0]}; // RL3
    wire [7:0] vhi_read  = {vid_high_rw, vid_sync2[4]}; // RL7
    wire [7:0] tcfg_read = {temp_sample_in.reading[0], temp_resv, temp_mode}; // RL15
    wire [7:0] st1_read  = 8'(temp_flag) << MCR_TEMP_STATUS_BIT;
    wire [7:0] st2_read  = 8'(chs_flag) << MCR_CHS_STATUS_BIT;

    assign rd_byte = (ptr == MCR_OFS_STATUS1)  ? st1_read  :
                     (ptr == MCR_OFS_STATUS2)  ? st2_read  :
                     (ptr == MCR_OFS_MASK1)    ? mask1     :
                     (ptr == MCR_OFS_MASK2)    ? mask2     :
                     (ptr == MCR_OFS_INTR_CLR) ? clr_read  :
                     (ptr == MCR_OFS_VID_FAN)  ? vfan_read :
                     (ptr == MCR_OFS_BUS_ADDR) ? bus_address :
                     (ptr == MCR_OFS_VID_HIGH) ? vhi_read  :
                     (ptr == MCR_OFS_TEMP_CFG) ? tcfg_read : 8'h00;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);

    a_pulse_start: assert property (pulse_go |=> chassis_intrusion_pin_oe_out) // RL1
        else $error("clear write did not start the chassis pulse");
    a_pulse_length: assert property ($fell(chassis_intrusion_pin_oe_out) |->
            $past(pulse_cnt) == CW'(CLEAR_PULSE_CYCLES - 1)) // RL19
        else $error("chassis pulse ended at the wrong count");
    a_clear_self: assert property (!chassis_intrusion_pin_oe_out |->
            !clr_read[MCR_INTR_CLR_BIT]) // RL2
        else $error("clear bit reads set with no pulse running");
    a_vid_mirror: assert property ($stable(cpu_voltage_code_inputs_in)[*3] |->
            vfan_read[3:0] == cpu_voltage_code_inputs_in) // RL3
        else $error("voltage code readback differs from steady pins");
    a_prescale_write: assert property (wr_en && ptr == MCR_OFS_VID_FAN |=>
            second_tach_prescale_out == $past(rx[7:6])) // RL5
        else $error("second prescale not taken from write");
    a_addr_powerup: assert property ($rose(bus_ready) |->
            bus_address[7:2] == MCR_BUS_ADDR_PREFIX) // RL6
        else $error("bus address prefix wrong at power-up");
    a_cmp_raise: assert property (mode_cmp && conv_done_in && above |=>
            temp_flag ##1 !system_management_alert_n_out || mask1[MCR_TEMP_STATUS_BIT]) // RL13
        else $error("comparator mode did not raise the alert");
    a_once_quiet: assert property (mode_once && !hot_armed && conv_done_in && !below
            && !rd_status1 |=> temp_flag == $past(temp_flag)) // RL11
        else $error("one-time mode flag changed without a crossing");
    a_read_clear: assert property (rd_status1 && !temp_set |=> !temp_flag) // RL17
        else $error("status read did not clear the temperature flag");
    a_dflt_rearm: assert property (mode_dflt && conv_done_in && hot_latched && !below
            |=> temp_flag) // RL9
        else $error("default mode did not raise again while hot");
    a_mask_gate: assert property (mask1[MCR_TEMP_STATUS_BIT] && !chs_flag
            |=> hw_int_n_out) // RL18
        else $error("masked temperature flag reached the interrupt");
endmodule
`default_nettype wire

// *** verilog/mcr_checks_placeholder_none.sv ***
`default_nettype none
`default_nettype wire

// *** sim/mcr_host_model.sv ***
`default_nettype none
module mcr_host_model #(
    parameter logic [6:0] DEV = 7'h2e
) (
    input  wire logic sys_clk_in,
    input  wire logic sda_in,
    output var logic  scl_out,
    output var logic  sda_oe_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    // ****************************************************************
    // bit and byte level, 22 cycles a phase
    // ****************************************************************
    task automatic hw();
        repeat (22) @(negedge sys_clk_in);
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_oe_out = ~b;
        hw();
        scl_out = 1'b1;
        hw();
        r = sda_in;
        scl_out = 1'b0;
    endtask
    task automatic start();
        sda_oe_out = 1'b0;
        hw();
        scl_out = 1'b1;
        hw();
        sda_oe_out = 1'b1;
        hw();
        scl_out = 1'b0;
    endtask
    task automatic stop();
        sda_oe_out = 1'b1;
        hw();
        scl_out = 1'b1;
        hw();
        sda_oe_out = 1'b0;
        hw();
    endtask
    // ninth slot always released: device acks writes, a released slot ends a read
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic k1, k2, k3;
        start();
        xfer({DEV, 1'b0}, q, k1);
        xfer(a, q, k2);
        xfer(d, q, k3);
        stop();
        ok = k1 & k2 & k3;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        logic k;
        start();
        xfer({DEV, 1'b0}, q, k);
        xfer(a, q, k);
        start();
        xfer({DEV, 1'b1}, q, k);
        xfer(8'hff, q, k);
        stop();
    endtask
endmodule
`default_nettype wire

// *** sim/tb_mcr_monitor_control.sv ***
`default_nettype none
module tb_mcr_monitor_control
    import mcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PULSE = 4000;
    logic sys_clk_in = 1'b0, srst_in = 1'b1, src = 1'b0, conv = 1'b0, v4 = 1'b1, link_clk = 1'b0;
    logic [3:0] cpu_voltage_code_inputs = 4'ha;
    mcr_temp_sample_type samp = '{9'h001, 8'd50, 8'd40};
    logic scl, host_oe, sda_oe, sda_o, chs_o, chs_oe, alert_n, int_n;
    logic [1:0] pre1, pre2;
    wire sda = (sda_oe ? sda_o : 1'b1) & ~host_oe;
    wire chassis_intrusion_pin = chs_oe ? chs_o : src;
    int error_cnt = 0, n_compared = 0, plen = 0;
    always #50 sys_clk_in = ~sys_clk_in;
    always #3 link_clk = ~link_clk;
    always @(posedge sys_clk_in) if (chs_oe) plen <= plen + 1;
    mcr_monitor_control #(.CLEAR_PULSE_CYCLES(PULSE)) i_mcr_monitor_control (
        .sys_clk_in(sys_clk_in), .srst_in(srst_in), .link_clk_in(link_clk), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe), .addr_select_high_pin_in(1'b1),
        .addr_select_low_pin_in(1'b0), .cpu_voltage_code_inputs_in(cpu_voltage_code_inputs),
        .voltage_code_fifth_input_in(v4), .chassis_intrusion_pin_in(chassis_intrusion_pin),
        .chassis_intrusion_pin_out(chs_o), .chassis_intrusion_pin_oe_out(chs_oe),
        .temp_sample_in(samp), .conv_done_in(conv), .first_tach_prescale_out(pre1),
        .second_tach_prescale_out(pre2), .system_management_alert_n_out(alert_n),
        .hw_int_n_out(int_n));
    mcr_host_model i_mcr_host_model (.sys_clk_in(sys_clk_in), .sda_in(sda),
        .scl_out(scl), .sda_oe_out(host_oe));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        i_mcr_host_model.rd(a, q);
        chk(q, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        i_mcr_host_model.wr(a, d, ok);
        chk({7'h0, ok}, 8'h01);
    endtask
    task automatic cv(input logic [8:0] r);
        samp.reading = r;
        conv = 1'b1;
        @(negedge sys_clk_in) conv = 1'b0;
        repeat (4) @(negedge sys_clk_in);
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_defaults();
        logic [7:0] q;
        logic k;
        rchk(MCR_OFS_INTR_CLR, 8'h00);
        rchk(MCR_OFS_BUS_ADDR, {MCR_BUS_ADDR_PREFIX, 2'b10});
        rchk(MCR_OFS_VID_HIGH, 8'h81);
        rchk(MCR_OFS_TEMP_CFG, 8'h81);
        wr(MCR_OFS_VID_HIGH, 8'hfe);
        rchk(MCR_OFS_VID_HIGH, 8'hff);
        v4 = 1'b0;
        rchk(MCR_OFS_VID_HIGH, 8'hfe);
        wr(MCR_OFS_TEMP_CFG, 8'h7d);
        rchk(MCR_OFS_TEMP_CFG, 8'hfd);
        rchk(8'h50, 8'h00);
        i_mcr_host_model.start();
        i_mcr_host_model.xfer(8'h22, q, k);
        i_mcr_host_model.stop();
        chk({7'h0, k}, 8'h00);
        $display("defaults done");
    endtask
    task automatic t_vid_fan();
        for (int c = 0; c < 4; c++) begin
            cpu_voltage_code_inputs = 4'(c * 5);
            wr(MCR_OFS_VID_FAN, {2'(3 - c), 2'(c), 4'hf});
            chk({4'h0, pre2, pre1}, {4'h0, 2'(3 - c), 2'(c)});
            rchk(MCR_OFS_VID_FAN, {2'(3 - c), 2'(c), 4'(c * 5)});
        end
        $display("vid fan done");
    endtask
    task automatic t_chassis();
        src = 1'b1;
        repeat (6) @(negedge sys_clk_in);
        src = 1'b0;
        chk({7'h0, int_n}, 8'h00);
        rchk(MCR_OFS_STATUS2, 8'h10);
        rchk(MCR_OFS_STATUS2, 8'h10);
        wr(MCR_OFS_MASK2, 8'h10);
        chk({7'h0, int_n}, 8'h01);
        wr(MCR_OFS_MASK2, 8'h00);
        plen = 0;
        wr(MCR_OFS_INTR_CLR, 8'h80);
        chk({7'h0, chassis_intrusion_pin}, 8'h00);
        rchk(MCR_OFS_INTR_CLR, 8'h80);
        for (int i = 0; i < PULSE && chs_oe; i++) @(negedge sys_clk_in);
        chk({7'h0, 1'(plen >= PULSE)}, 8'h01);
        rchk(MCR_OFS_INTR_CLR, 8'h00);
        rchk(MCR_OFS_STATUS2, 8'h00);
        $display("chassis done");
    endtask
    task automatic t_temp();
        // one-time first: it is the reset mode, no history from other modes
        cv(9'd120);
        rchk(MCR_OFS_STATUS1, 8'h10);
        cv(9'd120);
        rchk(MCR_OFS_STATUS1, 8'h00);
        cv(9'd60);
        rchk(MCR_OFS_STATUS1, 8'h10);
        cv(9'd60);
        rchk(MCR_OFS_STATUS1, 8'h00);
        wr(MCR_OFS_TEMP_CFG, 8'h00);
        cv(9'd120);
        chk({7'h0, int_n}, 8'h00);
        rchk(MCR_OFS_STATUS1, 8'h10);
        chk({7'h0, int_n}, 8'h01);
        cv(9'd90);
        rchk(MCR_OFS_STATUS1, 8'h10);
        cv(9'd60);
        rchk(MCR_OFS_STATUS1, 8'h00);
        wr(MCR_OFS_TEMP_CFG, 8'h03);
        cv(9'd120);
        chk({7'h0, alert_n}, 8'h01);
        wr(MCR_OFS_MASK1, 8'h10);
        chk({7'h0, int_n}, 8'h01);
        wr(MCR_OFS_MASK1, 8'h00);
        chk({7'h0, int_n}, 8'h00);
        rchk(MCR_OFS_STATUS1, 8'h10);
        wr(MCR_OFS_TEMP_CFG, 8'h02);
        cv(9'd120);
        chk({7'h0, alert_n}, 8'h00);
        cv(9'd90);
        chk({7'h0, alert_n}, 8'h01);
        cv(9'd120);
        rchk(MCR_OFS_STATUS1, 8'h10);
        chk({7'h0, alert_n}, 8'h01);
        $display("temperature done");
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #9000000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(negedge sys_clk_in);
        srst_in = 1'b0;
        repeat (8) @(negedge sys_clk_in);
        t_defaults();
        t_vid_fan();
        t_chassis();
        t_temp();
        tally_and_finish();
    end
endmodule
`default_nettype wire
